// File: rtl/hwmd_params.svh
`ifndef HWMD_PARAMS_SVH
`define HWMD_PARAMS_SVH

// ----------------------------------------
// memory layout
// ----------------------------------------
`define HWMD_MEM_BYTES 100
`define HWMD_ADDR_SNIP_COUNT 7'h00
`define HWMD_ADDR_SEQ_COUNT 7'h01
`define HWMD_ADDR_PTR_BASE 7'h02
`define HWMD_MAX_SNIPPETS 4'hF
`define HWMD_MAX_SEQUENCES 5'h10

// ----------------------------------------
// point byte fields
// ----------------------------------------
`define HWMD_PT_RAMP_BIT 7
`define HWMD_PT_DUR_HI 6
`define HWMD_PT_DUR_LO 4
`define HWMD_PT_AMP_HI 3
`define HWMD_PT_AMP_LO 0

// ----------------------------------------
// built-in silent snippet and signed amplitude fold codes
// ----------------------------------------
`define HWMD_SILENT_TB 4'h2
`define HWMD_SIGNED_MIN 4'h8
`define HWMD_SIGNED_NEG7 4'h9

`endif

// File: rtl/hwmd_pkg.sv
package hwmd_pkg;
	// lookup engine states, one-hot
	typedef enum logic [4:0] {
		HWMD_IDLE = 5'b0_0001,
		HWMD_RD_CNT = 5'b0_0010,
		HWMD_RD_END = 5'b0_0100,
		HWMD_RD_PREV = 5'b0_1000,
		HWMD_DONE = 5'b1_0000
	} hwmd_state_t;

	// result of a lookup
	typedef enum logic [1:0] {
		HWMD_OK = 2'h0,
		HWMD_BAD_ID = 2'h1,
		HWMD_BAD_PTR = 2'h2
	} hwmd_status_t;
endpackage

// File: rtl/hwmd_mem.sv
`timescale 1ns/1ps
`include "hwmd_params.svh"

// waveform byte store, one write and two read ports
module hwmd_mem
	import hwmd_pkg::*;
#(
	parameter int DEPTH = `HWMD_MEM_BYTES
)
(
	// clock
	input wire logic i_clk_sys,
	// write port
	input wire logic i_we,
	input wire logic [6:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// read ports, combinational
	input wire logic [6:0] i_raddr_a,
	output logic [7:0] o_rdata_a,
	input wire logic [6:0] i_raddr_b,
	output logic [7:0] o_rdata_b
);

	logic [7:0] mem [0:DEPTH-1];
	logic wr_ok;
	logic rd_ok_a;
	logic rd_ok_b;

	// out-of-range addresses write nothing and read zero
	assign wr_ok = i_we && (int'(i_waddr) < DEPTH);
	assign rd_ok_a = int'(i_raddr_a) < DEPTH;
	assign rd_ok_b = int'(i_raddr_b) < DEPTH;
	assign o_rdata_a = rd_ok_a ? mem[i_raddr_a] : 8'h00;
	assign o_rdata_b = rd_ok_b ? mem[i_raddr_b] : 8'h00;

	// storage has no reset; the loader fills it
	always_ff @(posedge i_clk_sys)
	begin
		if (wr_ok)
			mem[i_waddr] <= i_wdata;
	end
endmodule

// File: rtl/hwmd_point_unpack.sv
`timescale 1ns/1ps
`include "hwmd_params.svh"

// splits one point byte into flag, duration and amplitude
module hwmd_point_unpack
	import hwmd_pkg::*;
(
	// packed point
	input wire logic [7:0] i_byte,
	input wire logic i_accel_en,
	// unpacked fields
	output logic o_ramp_flag,
	output logic [3:0] o_timebases,
	output logic [4:0] o_point_amplitude
);

	logic [2:0] dur_code;
	logic [3:0] amp_raw;
	logic [3:0] amp_sym;

	assign o_ramp_flag = i_byte[`HWMD_PT_RAMP_BIT];
	assign dur_code = i_byte[`HWMD_PT_DUR_HI:`HWMD_PT_DUR_LO];
	assign amp_raw = i_byte[`HWMD_PT_AMP_HI:`HWMD_PT_AMP_LO];

	assign o_timebases = {1'b0, dur_code} + 4'h1;

	assign amp_sym = (amp_raw == `HWMD_SIGNED_MIN) ? `HWMD_SIGNED_NEG7 : amp_raw;

	// unsigned or signed, as 5-bit two's complement
	assign o_point_amplitude = i_accel_en ? {1'b0, amp_raw} : {amp_sym[3], amp_sym};
endmodule

// File: rtl/hwmd_decoder.sv
`timescale 1ns/1ps
`include "hwmd_params.svh"

module hwmd_decoder
	import hwmd_pkg::*;
#(
	parameter int MEM_BYTES = `HWMD_MEM_BYTES
)
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// loader write port
	input wire logic i_load_we,
	input wire logic [6:0] i_load_addr,
	input wire logic [7:0] i_load_data,
	// configuration
	input wire logic i_accel_en,
	// range lookup request
	input wire logic i_lookup_req,
	input wire logic i_lookup_is_seq,
	input wire logic [4:0] i_lookup_id,
	// range lookup answer
	output logic o_lookup_done,
	output logic [1:0] o_lookup_status,
	output logic [6:0] o_range_start,
	output logic [6:0] o_range_end,
	output logic o_range_builtin,
	// point fetch request
	input wire logic i_point_req,
	input wire logic [6:0] i_point_addr,
	input wire logic i_first_in_seq,
	input wire logic i_seq_looping,
	// point fetch answer
	output logic o_point_valid,
	output logic o_ramp_flag,
	output logic [3:0] o_timebases,
	output logic [4:0] o_point_amplitude,
	output logic [4:0] o_start_amplitude,
	// header status
	output logic [3:0] o_snippet_count,
	output logic [4:0] o_sequence_count
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// port a walks the header for lookups, port b serves point fetches,
	// so a fetch never waits behind a lookup in progress
	logic [6:0] rd_addr_a;
	logic [7:0] rd_data_a;
	logic [7:0] rd_data_b;

	hwmd_mem #(
		.DEPTH(MEM_BYTES)
	) u_mem (
		.i_clk_sys(i_clk_sys),
		.i_we(i_load_we),
		.i_waddr(i_load_addr),
		.i_wdata(i_load_data),
		.i_raddr_a(rd_addr_a),
		.o_rdata_a(rd_data_a),
		.i_raddr_b(i_point_addr),
		.o_rdata_b(rd_data_b)
	);

	// ----------------------------------------
	// lookup engine
	// ----------------------------------------
	// one header byte per state: count, sequence count, end, prior end;
	// done rises three edges after the request edge, and requests seen
	// while busy are dropped, so the host spaces them five cycles apart
	hwmd_state_t state_q;
	hwmd_state_t state_d;
	logic is_seq_q;
	logic [4:0] id_q;
	logic [7:0] snip_cnt_q;
	logic [7:0] seq_cnt_q;
	logic [7:0] end_q;
	logic done_q;
	logic [1:0] status_q;
	logic [6:0] start_q;
	logic [6:0] rend_q;
	logic builtin_q;
	logic [6:0] ptr_addr;
	logic id_ok;
	logic first_item;
	logic [7:0] prev_end;
	logic ptr_ok;

	// snippets from one, sequences from zero
	assign ptr_addr = (is_seq_q ? 7'(snip_cnt_q[3:0]) + 7'(id_q) : 7'(id_q) - 7'h1)
		+ `HWMD_ADDR_PTR_BASE;
	// sequence zero follows the last snippet, so only with no
	// snippets stored does it start right after the pointer table
	assign first_item = is_seq_q
		? (id_q == 5'h00) && (snip_cnt_q[3:0] == 4'h0)
		: (id_q == 5'h01);

	// id bounded by stored and layout counts
	assign id_ok = is_seq_q
		? (id_q < 5'(seq_cnt_q[4:0])) && (id_q < `HWMD_MAX_SEQUENCES)
		: (id_q <= 5'(snip_cnt_q[3:0])) && (id_q <= 5'(`HWMD_MAX_SNIPPETS));

	// read address per state, header first
	always_comb
	begin
		rd_addr_a = `HWMD_ADDR_SNIP_COUNT;
		case (state_q)
			HWMD_RD_CNT: rd_addr_a = `HWMD_ADDR_SEQ_COUNT;
			HWMD_RD_END: rd_addr_a = ptr_addr;
			HWMD_RD_PREV: rd_addr_a = ptr_addr - 7'h1;
			default: rd_addr_a = `HWMD_ADDR_SNIP_COUNT;
		endcase
	end

	// pointers are absolute, end must be inside memory
	assign ptr_ok = end_q < 8'(MEM_BYTES);

	// first item starts after the pointer table
	assign prev_end = first_item
		? 8'(`HWMD_ADDR_PTR_BASE) + 8'(snip_cnt_q[3:0]) + seq_cnt_q[7:0] - 8'h1
		: rd_data_a;

	// next state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			HWMD_IDLE: if (i_lookup_req) state_d = HWMD_RD_CNT;
			HWMD_RD_CNT: state_d = HWMD_RD_END;
			HWMD_RD_END: state_d = HWMD_RD_PREV;
			HWMD_RD_PREV: state_d = HWMD_DONE;
			HWMD_DONE: state_d = HWMD_IDLE;
			default: state_d = HWMD_IDLE;
		endcase
	end

	// state register
	// every busy state moves on unconditionally, so nothing can stall it
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			state_q <= HWMD_IDLE;
		else
			state_q <= state_d;
	end

	// request capture; count read in idle
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			is_seq_q <= 1'b0;
			id_q <= 5'h00;
			snip_cnt_q <= 8'h00;
		end
		else if (state_q == HWMD_IDLE && i_lookup_req)
		begin
			is_seq_q <= i_lookup_is_seq;
			id_q <= i_lookup_id;
			snip_cnt_q <= rd_data_a;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			seq_cnt_q <= 8'h00;
			end_q <= 8'h00;
		end
		else if (state_q == HWMD_RD_CNT)
			seq_cnt_q <= rd_data_a;
		else if (state_q == HWMD_RD_END)
			end_q <= rd_data_a;
	end

	// answer registers, held until next lookup except done, which pulses for one cycle
	// fields change only at the end of a lookup so playback may read late
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			done_q <= 1'b0;
			status_q <= HWMD_OK;
			start_q <= 7'h00;
			rend_q <= 7'h00;
			builtin_q <= 1'b0;
		end
		else
		begin
			done_q <= (state_q == HWMD_RD_PREV);
			if (state_q == HWMD_RD_PREV)
			begin
				builtin_q <= !is_seq_q && (id_q == 5'h00);
				start_q <= 7'(prev_end + 8'h1);
				rend_q <= end_q[6:0];
				if (!is_seq_q && id_q == 5'h00)
					status_q <= HWMD_OK;
				else if (!id_ok)
					status_q <= HWMD_BAD_ID;
				else if (!ptr_ok)
					status_q <= HWMD_BAD_PTR;
				else
					status_q <= HWMD_OK;
			end
		end
	end

	// ----------------------------------------
	// point fetch
	// ----------------------------------------
	// one fetch per request, answered on the next edge; there is no queue,
	// so a request every cycle simply replaces the held fields
	logic [7:0] pt_byte;
	logic u_ramp;
	logic [3:0] u_tb;
	logic [4:0] u_amp;
	logic pv_q;
	logic ramp_q;
	logic [3:0] tb_q;
	logic [4:0] amp_q;
	logic [4:0] start_amp_q;
	logic [4:0] last_amp_q;
	logic [4:0] start_amp_d;

	// unmapped point address reads as silence
	assign pt_byte = (int'(i_point_addr) < MEM_BYTES) ? rd_data_b : 8'h00;

	hwmd_point_unpack u_unpack (
		.i_byte(pt_byte),
		.i_accel_en(i_accel_en),
		.o_ramp_flag(u_ramp),
		.o_timebases(u_tb),
		.o_point_amplitude(u_amp)
	);

	// implicit zero only for first snippet when not looping
	assign start_amp_d = (i_first_in_seq && !i_seq_looping) ? 5'h00 : last_amp_q;

	// flag and start level handed to playback
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			pv_q <= 1'b0;
			ramp_q <= 1'b0;
			tb_q <= 4'h0;
			amp_q <= 5'h00;
			start_amp_q <= 5'h00;
			last_amp_q <= 5'h00;
		end
		else
		begin
			pv_q <= i_point_req;
			if (i_point_req)
			begin
				ramp_q <= u_ramp;
				tb_q <= u_tb;
				amp_q <= u_amp;
				start_amp_q <= start_amp_d;
				last_amp_q <= u_amp;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_lookup_done = done_q;
	assign o_lookup_status = status_q;
	assign o_range_start = start_q;
	assign o_range_end = rend_q;
	assign o_range_builtin = builtin_q;
	assign o_point_valid = pv_q;
	assign o_ramp_flag = ramp_q;
	assign o_timebases = tb_q;
	assign o_point_amplitude = amp_q;
	assign o_start_amplitude = start_amp_q;
	assign o_snippet_count = snip_cnt_q[3:0];
	assign o_sequence_count = seq_cnt_q[4:0];
endmodule

// File: verification/hwmd_decoder_monitor.sv
`timescale 1ns/1ps
// ----------
// port checks
// ----------
module hwmd_decoder_monitor
	import hwmd_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// requests
	input wire logic i_accel_en,
	input wire logic i_lookup_req,
	input wire logic i_lookup_is_seq,
	input wire logic [4:0] i_lookup_id,
	input wire logic i_point_req,
	input wire logic i_first_in_seq,
	input wire logic i_seq_looping,
	// answers
	input wire logic o_lookup_done,
	input wire logic [1:0] o_lookup_status,
	input wire logic o_range_builtin,
	input wire logic o_point_valid,
	input wire logic [4:0] o_point_amplitude,
	input wire logic [4:0] o_start_amplitude
);
	// one domain, clock and reset set once
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	// done only four cycles after a request
	a_done_cause:
		assert property (o_lookup_done |-> $past(i_lookup_req, 4)) else $error("stray done");
	a_point_answer:
		assert property (i_point_req |=> o_point_valid) else $error("no point");
	a_amp_unsigned:
		assert property (o_point_valid && $past(i_accel_en) |-> !o_point_amplitude[4])
		else $error("bad unsigned amp");
	// -8 folds to -7, so 8..24 never shows
	a_amp_signed:
		assert property (o_point_valid && !$past(i_accel_en)
			|-> !(o_point_amplitude inside {[8:24]})) else $error("bad signed amp");
	a_start_zero:
		assert property (o_point_valid && $past(i_first_in_seq) && !$past(i_seq_looping)
			|-> o_start_amplitude == 5'h00) else $error("start not zero");
	a_start_prev:
		assert property (o_point_valid && !($past(i_first_in_seq) && !$past(i_seq_looping))
			|-> o_start_amplitude == $past(o_point_amplitude)) else $error("start not prior");
	a_silent_id:
		assert property (o_lookup_done && !$past(i_lookup_is_seq, 4)
			&& $past(i_lookup_id, 4) == 5'h00 |-> o_range_builtin) else $error("no builtin");
	a_bad_id:
		assert property (o_lookup_done && $past(i_lookup_id[4], 4)
			|-> o_lookup_status == HWMD_BAD_ID) else $error("id over limit");
endmodule
bind hwmd_decoder hwmd_decoder_monitor i_mon (.i_clk_sys, .i_rst, .i_accel_en, .i_lookup_req,
	.i_lookup_is_seq, .i_lookup_id, .i_point_req, .i_first_in_seq, .i_seq_looping,
	.o_lookup_done, .o_lookup_status, .o_range_builtin, .o_point_valid, .o_point_amplitude,
	.o_start_amplitude);

// File: verification/hwmd_loader.sv
`timescale 1ns/1ps
// ----------
// host loader
// ----------
module hwmd_loader
(
	// clock
	input wire logic i_clk_sys,
	// store write port
	output logic o_we = 1'b0,
	output logic [6:0] o_addr = 7'h00,
	output logic [7:0] o_data = 8'h00
);
	logic [7:0] img [100];
	task load(input logic slow);
		for (int a = 0; a < 100; a++)
		begin
			@(negedge i_clk_sys);
			o_addr = 7'(a);
			o_data = img[a];
			o_we = 1'b1;
			// slow host idles with scrambled data
			if (slow)
			begin
				@(negedge i_clk_sys);
				o_we = 1'b0;
				o_data = ~o_data;
			end
		end
		@(negedge i_clk_sys);
		o_we = 1'b0;
		o_data = ~o_data;
	endtask
endmodule

// File: verification/hwmd_decoder_tb.sv
`timescale 1ns/1ps
// ----------
// decoder bench
// ----------
module hwmd_decoder_tb;
	import hwmd_pkg::*;
	logic i_clk_sys, i_rst, i_accel_en, i_lookup_req, i_lookup_is_seq, i_point_req;
	logic i_first_in_seq, i_seq_looping, i_load_we, o_lookup_done, o_range_builtin;
	logic o_point_valid, o_ramp_flag;
	logic [1:0] o_lookup_status;
	logic [3:0] o_timebases, o_snippet_count;
	logic [4:0] i_lookup_id, o_point_amplitude, o_start_amplitude, o_sequence_count, prev_amp;
	logic [6:0] i_point_addr, i_load_addr, o_range_start, o_range_end;
	logic [7:0] i_load_data;
	int errors, n_checks;
	hwmd_loader i_ld (.i_clk_sys, .o_we(i_load_we), .o_addr(i_load_addr), .o_data(i_load_data));
	hwmd_decoder i_hwmd_decoder (.i_clk_sys, .i_rst, .i_load_we, .i_load_addr, .i_load_data,
		.i_accel_en, .i_lookup_req, .i_lookup_is_seq, .i_lookup_id, .o_lookup_done,
		.o_lookup_status, .o_range_start, .o_range_end, .o_range_builtin, .i_point_req,
		.i_point_addr, .i_first_in_seq, .i_seq_looping, .o_point_valid, .o_ramp_flag,
		.o_timebases, .o_point_amplitude, .o_start_amplitude, .o_snippet_count,
		.o_sequence_count);
	task chk(input logic [7:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// ranges worked out from the image: item starts after the prior pointer
	task lk(input logic s, input logic [4:0] id);
		int x;
		logic [7:0] e, b;
		logic [1:0] st;
		x = s ? i_ld.img[0] + id : id - 1;
		e = i_ld.img[2 + x];
		b = x ? i_ld.img[1 + x] + 8'h01 : i_ld.img[0] + i_ld.img[1] + 8'h02;
		st = id[4] ? HWMD_BAD_ID : e > 8'h63 ? HWMD_BAD_PTR : HWMD_OK;
		i_lookup_is_seq = s;
		i_lookup_id = id;
		i_lookup_req = 1'b1;
		@(negedge i_clk_sys);
		i_lookup_req = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		chk(o_lookup_done, 0);
		@(negedge i_clk_sys);
		chk(o_lookup_done, 1);
		chk(o_snippet_count, i_ld.img[0]);
		chk(o_sequence_count, i_ld.img[1]);
		chk(o_range_builtin, !(s || id));
		if (s || id)
			chk(o_lookup_status, st);
		if (st == HWMD_OK && (s || id))
		begin
			chk(o_range_start, b);
			chk(o_range_end, e);
		end
		// done stands one cycle; the engine is idle again after this edge
		@(negedge i_clk_sys);
		chk(o_lookup_done, 0);
	endtask
	task pt(input logic [6:0] a, input logic ac, f, lp);
		logic [7:0] b;
		logic [4:0] e;
		b = i_ld.img[a];
		e = ac ? {1'b0, b[3:0]} : b[3:0] == 4'h8 ? 5'h19 : {b[3], b[3:0]};
		@(negedge i_clk_sys);
		{i_point_addr, i_accel_en, i_first_in_seq, i_seq_looping} = {a, ac, f, lp};
		i_point_req = 1'b1;
		@(negedge i_clk_sys);
		i_point_req = 1'b0;
		chk(o_point_valid, 1);
		chk(o_ramp_flag, b[7]);
		chk(o_timebases, b[6:4] + 8'h01);
		chk(o_point_amplitude, e);
		chk(o_start_amplitude, f && !lp ? 5'h00 : prev_amp);
		prev_amp = e;
	endtask
	task t_header();
		lk(1'b0, 5'h00);
		lk(1'b0, 5'h01);
		lk(1'b0, 5'h02);
		lk(1'b1, 5'h00);
		lk(1'b1, 5'h01);
		lk(1'b0, 5'h10);
		lk(1'b1, 5'h1f);
	endtask
	// a request while busy is dropped silently
	task t_busy();
		lk(1'b0, 5'h01);
		i_lookup_is_seq = 1'b0;
		i_lookup_id = 5'h01;
		i_lookup_req = 1'b1;
		@(negedge i_clk_sys);
		// still high into the busy window, now with another id
		i_lookup_id = 5'h02;
		@(negedge i_clk_sys);
		i_lookup_req = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		chk(o_lookup_done, 1);
		chk(o_range_end, i_ld.img[2]);
		chk(o_range_start, i_ld.img[0] + i_ld.img[1] + 8'h02);
		repeat (4)
		begin
			@(negedge i_clk_sys);
			chk(o_lookup_done, 0);
		end
	endtask
	// every duration and amplitude code, both modes
	task t_points();
		for (int a = 6; a < 31; a++)
			pt(7'(a), 1'b1, 1'b0, 1'b0);
		for (int a = 6; a < 31; a++)
			pt(7'(a), 1'b0, 1'b0, 1'b1);
		pt(7'h0d, 1'b0, 1'b1, 1'b0);
		pt(7'h0e, 1'b1, 1'b1, 1'b1);
	endtask
	task t_badptr();
		i_ld.img[5] = 8'h64;
		i_ld.load(1'b1);
		lk(1'b1, 5'h01);
	endtask
	task end_sim();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		i_clk_sys = 1'b0;
		forever
			#25 i_clk_sys = ~i_clk_sys;
	end
	// watchdog, run needs about 465 cycles
	initial
	begin
		#(50 * 5000);
		errors++;
		end_sim();
	end
	// two snippets, two sequences, last sequence ends at byte 99
	initial
	begin
		i_rst = 1'b1;
		{i_accel_en, i_lookup_req, i_lookup_is_seq, i_point_req, i_lookup_id} = 9'h000;
		{i_first_in_seq, i_seq_looping, i_point_addr} = 9'h000;
		{errors, n_checks, prev_amp} = '0;
		for (int a = 0; a < 100; a++)
			i_ld.img[a] = 8'(a * 8'h19);
		i_ld.img[0] = 8'h02;
		i_ld.img[1] = 8'h02;
		i_ld.img[2] = 8'h07;
		i_ld.img[3] = 8'h0a;
		i_ld.img[4] = 8'h0c;
		i_ld.img[5] = 8'h63;
		repeat (6) @(negedge i_clk_sys);
		i_rst = 1'b0;
		i_ld.load(1'b0);
		t_header();
		t_busy();
		t_points();
		t_badptr();
		end_sim();
	end
endmodule
